/* File: verilog/tag_mem_pkg.sv */
// Constants for the tag block-memory write-policy logic.
// Assumes a single core clock domain and 32-bit blocks addressed by an 8-bit block number.
`default_nettype none
package tag_mem_pkg;

    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int MEM_ADDR_W = 7;

    // Block map.
    localparam logic [7:0] OTP_LAST = 8'h04;
    localparam logic [7:0] CNT_A_ADDR = 8'h05;
    localparam logic [7:0] CNT_REFILL_ADDR = 8'h06;
    localparam logic [7:0] USER_FIRST = 8'h07;
    localparam logic [7:0] USER_LAST = 8'h7F;
    localparam logic [7:0] LOCK_PAIR_LAST = 8'h08;
    localparam logic [7:0] LOCKABLE_LAST = 8'h0F;
    localparam logic [7:0] SYS_ADDR = 8'hFF;

    // Reset values.
    localparam logic [31:0] CNT_A_RESET = 32'hFFFF_FFFE;
    localparam logic [31:0] CNT_REFILL_RESET = 32'hFFFF_FFFF;
    localparam logic [23:0] SYS_UPPER_RESET = 24'hFF_FFFF;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    // Field positions inside the system block and the refill counter.
    localparam int LOCK_LSB = 24;
    localparam int LOCK_W = 8;
    localparam int ID_W = 8;
    localparam int REFILL_LSB = 21;

    // Programming cycle length in core clocks; arbitrary, shortened for simulation by parameter.
    localparam int PROG_CYCLES = 16;
    localparam int PROG_CNT_W = 16;

    // Seed of the random identifier generator; any non-zero value works.
    localparam logic [7:0] LFSR_SEED = 8'hA5;

endpackage : tag_mem_pkg
`default_nettype wire

/* File: verilog/mem_bus_if.sv */
// Carrier between the write-policy controller and its block memory.
// Assumes both ends run on core_clk.
`timescale 1ns/1ps
`default_nettype none
interface mem_bus_if;
    logic we;
    logic [6:0] waddr;
    logic [31:0] wdata;
    logic [6:0] raddr;
    logic [31:0] rdata;

    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : mem_bus_if
`default_nettype wire

/* File: verilog/block_ram.sv */
// Storage array for blocks 0 to 127 with a registered read port.
// Assumes one write and one read per clock, both on core_clk.
`timescale 1ns/1ps
`default_nettype none
module block_ram (
    input wire logic core_clk,
    mem_bus_if.mem bus
);

    logic [31:0] mem_q [128];
    logic [31:0] rdata_q;

    // Array contents are nonvolatile in spirit, so they carry no reset.
    always_ff @(posedge core_clk) begin
        if (bus.we) begin
            mem_q[bus.waddr] <= bus.wdata;
        end
        rdata_q <= mem_q[bus.raddr];
    end

    assign bus.rdata = rdata_q;

endmodule : block_ram
`default_nettype wire

/* File: verilog/tag_memory_write_policy.sv */
// Write-policy controller for a contactless tag's 32-bit block memory.
// Assumes commands arrive already decoded on core_clk; the field and option straps are pins.
//
// Contract
// (RULE1) A counter block write is taken only if the new value is strictly below the stored one.
// (RULE2) The first counter starts at FFFFFFFE and the refill counter at FFFFFFFF.
// (RULE3) A counter that holds zero is exhausted and never changes again.
// (RULE4) Losing the field during a counter programming cycle keeps the old counter value.
// (RULE5) Changing any of the top eleven refill-counter bits enters erase mode for blocks 0 to 4.
// (RULE6) Erase mode lasts until the field drops or a selection command arrives.
// (RULE7) User blocks 7 to 127 are readable, writable and erased before each write.
// (RULE8) The top eight bits of block 255 are lock bits for user blocks 7 to 15.
// (RULE9) Lock bit 24 at zero protects blocks 7 and 8, and bits 25 to 31 protect blocks 9 to 15.
// (RULE10) Lock bits cannot be erased and protected blocks stay read-only for good.
// (RULE11) A system block write stores the AND of old and new data without erase.
// (RULE12) A system block of all zeros accepts no further update.
// (RULE13) With the fixed-identifier option the low byte of block 255 is the selection identifier.
// (RULE14) Outside erase mode blocks 0 to 4 only clear bits and freeze once all zero.
// (RULE15) In erase mode a write to blocks 0 to 4 replaces the old contents exactly.
// (RULE16) A refused counter write leaves the counter unchanged and reports no error.
`timescale 1ns/1ps
`default_nettype none
module tag_memory_write_policy #(
    parameter int PROG_CYCLES = tag_mem_pkg::PROG_CYCLES,
    parameter logic [7:0] FIXED_ID = 8'h3C // Arbitrary value of the mask-programmed identifier.
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic field_on,
    input wire logic fixed_id_opt,
    input wire logic select_cmd,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_addr,
    input wire logic [31:0] cmd_wdata,
    output logic cmd_ready,
    output logic rd_valid,
    output logic [31:0] rd_data,
    output logic wr_done,
    output logic erase_mode,
    output logic [7:0] tag_selection_id
);

    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_RFETCH = 5'b00010,
        S_RDONE = 5'b00100,
        S_WFETCH = 5'b01000,
        S_WPROG = 5'b10000
    } state_e;

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers.

    // True when a user block in the lockable range is write-protected by the lock byte.
    function automatic logic block_locked(input logic [7:0] addr, input logic [7:0] lock);
        logic [7:0] idx;
        idx = addr - tag_mem_pkg::LOCK_PAIR_LAST;
        block_locked = 1'b0;
        if (addr >= tag_mem_pkg::USER_FIRST && addr <= tag_mem_pkg::LOCK_PAIR_LAST) begin
            block_locked = ~lock[0]; // see (RULE9)
        end else if (addr > tag_mem_pkg::LOCK_PAIR_LAST && addr <= tag_mem_pkg::LOCKABLE_LAST) begin
            block_locked = ~lock[idx[2:0]]; // see (RULE9)
        end
    endfunction : block_locked

    // True for the addresses held in the block memory array.
    function automatic logic in_array(input logic [7:0] addr);
        in_array = (addr <= tag_mem_pkg::USER_LAST);
    endfunction : in_array

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    logic field_m_q, field_s_q, field_prev_q;
    logic opt_m_q, opt_s_q;

    // The field and option straps are asynchronous pins; two stages before use.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            field_m_q <= 1'b0;
            field_s_q <= 1'b0;
            field_prev_q <= 1'b0;
            opt_m_q <= 1'b0;
            opt_s_q <= 1'b0;
        end else begin
            field_m_q <= field_on;
            field_s_q <= field_m_q;
            field_prev_q <= field_s_q;
            opt_m_q <= fixed_id_opt;
            opt_s_q <= opt_m_q;
        end
    end

    logic field_drop, field_rise;
    assign field_drop = field_prev_q & ~field_s_q;
    assign field_rise = field_s_q & ~field_prev_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Controller state.

    mem_bus_if bus ();

    block_ram u_ram (
        .core_clk(core_clk),
        .bus(bus)
    );

    state_e state_q, state_d;
    logic [31:0] cnt_a_q, cnt_a_d;
    logic [31:0] cnt_r_q, cnt_r_d;
    logic [31:0] sys_q, sys_d;
    logic erase_q, erase_d;
    logic [7:0] addr_q, addr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [31:0] old_q, old_d;
    logic [15:0] prog_q, prog_d;
    logic [31:0] rd_data_q, rd_data_d;
    logic rd_valid_q, rd_valid_d;
    logic wr_done_q, wr_done_d;
    logic [7:0] lfsr_q, lfsr_d;
    logic [7:0] rand_id_q, rand_id_d;
    logic [31:0] new_val;
    logic [31:0] old_word;

    // Stored value of the addressed block; unmapped addresses read as zero.
    always_comb begin
        old_word = tag_mem_pkg::ZERO_WORD;
        if (addr_q == tag_mem_pkg::CNT_A_ADDR) begin
            old_word = cnt_a_q;
        end else if (addr_q == tag_mem_pkg::CNT_REFILL_ADDR) begin
            old_word = cnt_r_q;
        end else if (addr_q == tag_mem_pkg::SYS_ADDR) begin
            old_word = sys_q;
        end else if (in_array(addr_q)) begin
            old_word = bus.rdata;
        end
    end

    // Value that the programming cycle will commit, per area policy.
    always_comb begin
        new_val = old_q;
        if (addr_q <= tag_mem_pkg::OTP_LAST) begin
            if (erase_q) begin
                new_val = wdata_q; // see (RULE15)
            end else if (old_q != tag_mem_pkg::ZERO_WORD) begin
                new_val = old_q & wdata_q; // see (RULE14)
            end
        end else if (addr_q == tag_mem_pkg::CNT_A_ADDR || addr_q == tag_mem_pkg::CNT_REFILL_ADDR) begin
            // Refused values simply keep the old word; the reader sees no error.
            if (old_q != tag_mem_pkg::ZERO_WORD && wdata_q < old_q) begin // see (RULE3)
                new_val = wdata_q; // see (RULE1) see (RULE16)
            end
        end else if (addr_q == tag_mem_pkg::SYS_ADDR) begin
            if (old_q != tag_mem_pkg::ZERO_WORD) begin // see (RULE12)
                new_val = old_q & wdata_q; // see (RULE11) see (RULE10)
            end
        end else if (in_array(addr_q)) begin
            if (!block_locked(addr_q, sys_q[tag_mem_pkg::LOCK_LSB +: tag_mem_pkg::LOCK_W])) begin
                new_val = wdata_q; // see (RULE7) see (RULE8) see (RULE10)
            end
        end
    end

    // Next-state logic for the command sequencer and the block registers.
    always_comb begin
        state_d = state_q;
        cnt_a_d = cnt_a_q;
        cnt_r_d = cnt_r_q;
        sys_d = sys_q;
        erase_d = erase_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        old_d = old_q;
        prog_d = prog_q;
        rd_data_d = rd_data_q;
        rd_valid_d = 1'b0;
        wr_done_d = 1'b0;
        lfsr_d = {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
        rand_id_d = field_rise ? lfsr_q : rand_id_q;
        bus.we = 1'b0;
        bus.waddr = addr_q[6:0];
        bus.wdata = new_val;
        bus.raddr = addr_q[6:0];
        unique case (state_q)
            S_IDLE: begin
                if (cmd_valid && field_s_q) begin
                    addr_d = cmd_addr;
                    wdata_d = cmd_wdata;
                    bus.raddr = cmd_addr[6:0];
                    state_d = cmd_write ? S_WFETCH : S_RFETCH;
                end
            end
            S_RFETCH: begin
                state_d = S_RDONE;
            end
            S_RDONE: begin
                rd_data_d = old_word; // see (RULE7)
                rd_valid_d = 1'b1;
                state_d = S_IDLE;
            end
            S_WFETCH: begin
                old_d = old_word;
                prog_d = '0;
                state_d = S_WPROG;
            end
            S_WPROG: begin
                prog_d = prog_q + 16'h0001;
                if (!field_s_q) begin
                    // Tear: nothing is committed, every block keeps its old value.
                    state_d = S_IDLE; // see (RULE4)
                end else if (prog_q == PROG_CYCLES[15:0] - 16'h0001) begin
                    state_d = S_IDLE;
                    wr_done_d = 1'b1;
                    if (addr_q == tag_mem_pkg::CNT_A_ADDR) begin
                        cnt_a_d = new_val;
                    end else if (addr_q == tag_mem_pkg::CNT_REFILL_ADDR) begin
                        cnt_r_d = new_val;
                        if (new_val[31:tag_mem_pkg::REFILL_LSB] != old_q[31:tag_mem_pkg::REFILL_LSB]) begin
                            erase_d = 1'b1; // see (RULE5)
                        end
                    end else if (addr_q == tag_mem_pkg::SYS_ADDR) begin
                        sys_d = new_val;
                    end else if (in_array(addr_q)) begin
                        bus.we = 1'b1;
                    end
                end
            end
        endcase
        if (select_cmd || field_drop) begin
            erase_d = 1'b0; // see (RULE6)
        end
    end

    // Register stage; counters and system block take their delivery values at reset.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= S_IDLE;
            cnt_a_q <= tag_mem_pkg::CNT_A_RESET; // see (RULE2)
            cnt_r_q <= tag_mem_pkg::CNT_REFILL_RESET; // see (RULE2)
            sys_q <= {tag_mem_pkg::SYS_UPPER_RESET, FIXED_ID};
            erase_q <= 1'b0;
            addr_q <= '0;
            wdata_q <= tag_mem_pkg::ZERO_WORD;
            old_q <= tag_mem_pkg::ZERO_WORD;
            prog_q <= '0;
            rd_data_q <= tag_mem_pkg::ZERO_WORD;
            rd_valid_q <= 1'b0;
            wr_done_q <= 1'b0;
            lfsr_q <= tag_mem_pkg::LFSR_SEED;
            rand_id_q <= tag_mem_pkg::LFSR_SEED;
        end else begin
            state_q <= state_d;
            cnt_a_q <= cnt_a_d;
            cnt_r_q <= cnt_r_d;
            sys_q <= sys_d;
            erase_q <= erase_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            old_q <= old_d;
            prog_q <= prog_d;
            rd_data_q <= rd_data_d;
            rd_valid_q <= rd_valid_d;
            wr_done_q <= wr_done_d;
            lfsr_q <= lfsr_d;
            rand_id_q <= rand_id_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign cmd_ready = (state_q == S_IDLE) & field_s_q;
    assign rd_valid = rd_valid_q;
    assign rd_data = rd_data_q;
    assign wr_done = wr_done_q;
    assign erase_mode = erase_q;
    // The fixed option replaces the random identifier at the output; the generator keeps running and latching.
    assign tag_selection_id = opt_s_q ? sys_q[tag_mem_pkg::ID_W-1:0] : rand_id_q; // see (RULE13)

endmodule : tag_memory_write_policy
`default_nettype wire

/* File: sim/tag_mem_asserts.sv */
// Checker for the tag write-policy controller, bound to its top-level ports.
// Assumes one core clock and that PROG_CYCLES matches the bound design.
`timescale 1ns/1ps
`default_nettype none
module tag_mem_asserts #(
    parameter int PROG_CYCLES = 16
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic field_on,
    input wire logic fixed_id_opt,
    input wire logic select_cmd,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_addr,
    input wire logic [31:0] cmd_wdata,
    input wire logic cmd_ready,
    input wire logic rd_valid,
    input wire logic [31:0] rd_data,
    input wire logic wr_done,
    input wire logic erase_mode,
    input wire logic [7:0] tag_selection_id
);
    localparam int WR_LAT = PROG_CYCLES + 2;
    logic rd_take;
    logic wr_take;
    ////////////////////////////////////////
    // Requests taken this cycle, split by kind.
    assign rd_take = cmd_valid && cmd_ready && !cmd_write;
    assign wr_take = cmd_valid && cmd_ready && cmd_write;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence read_answer_s;
        !rd_valid ##1 !rd_valid ##1 rd_valid;
    endsequence
    ////////////////////////////////////////
    rd_latency_a: assert property (rd_take |=> read_answer_s)
        else $error("read answer not three cycles after take");
    done_cause_a: assert property (wr_done |-> $past(wr_take, WR_LAT))
        else $error("write done without a write taken");
    ready_drop_a: assert property (rd_take || wr_take |=> !cmd_ready)
        else $error("ready stayed high after a take");
    erase_clear_a: assert property (select_cmd |=> !erase_mode)
        else $error("erase mode kept after selection");
    erase_set_a: assert property ($rose(erase_mode) |-> wr_done)
        else $error("erase mode rose without a write");
    rd_hold_a: assert property (!rd_valid |-> $stable(rd_data))
        else $error("read data moved without an answer");
    field_gate_a: assert property (!field_on [*3] |-> !cmd_ready)
        else $error("ready high without field");
    id_fixed_a: assert property (fixed_id_opt [*4] ##0 !(wr_done || $past(wr_done))
        |-> $stable(tag_selection_id)) else $error("fixed identifier changed");
endmodule : tag_mem_asserts
`default_nettype wire

/* File: sim/reader_model.sv */
// Reader model issuing block reads and writes on the command port.
// Assumes ready stays high until a request is taken.
`timescale 1ns/1ps
`default_nettype none
module reader_model (
    input wire logic core_clk,
    input wire logic cmd_ready,
    input wire logic rd_valid,
    input wire logic [31:0] rd_data,
    input wire logic wr_done,
    output logic cmd_valid,
    output logic cmd_write,
    output logic [7:0] cmd_addr,
    output logic [31:0] cmd_wdata
);
    ////////////////////////////////////////
    // Idle lines at time zero.
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_addr = 8'h00;
        cmd_wdata = 32'h0000_0000;
    end
    // One transfer after some idle cycles; valid drops and the released address and data lines carry the inverse,
    // so a stale request never looks valid.
    task automatic xfer(input int idle, input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q, output logic ok);
        int n;
        q = 32'h0000_0000;
        ok = 1'b0;
        n = 0;
        repeat (idle + 1) @(posedge core_clk);
        #1;
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_addr = a;
        cmd_wdata = d;
        do begin
            @(negedge core_clk);
            n++;
        end while (!cmd_ready && n < 200);
        @(posedge core_clk);
        #1;
        cmd_valid = 1'b0;
        cmd_addr = ~a;
        cmd_wdata = ~d;
        for (n = 0; n < 40 && !ok; n++) begin
            @(posedge core_clk);
            #1;
            ok = w ? wr_done : rd_valid;
            q = rd_data;
        end
    endtask : xfer
endmodule : reader_model
`default_nettype wire

/* File: sim/tb_top.sv */
// Self-checking bench for the tag write-policy controller.
// Assumes the reader model and the checker of this folder.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin mismatches++; \
    $display("[ERR] %s expected %h seen %h", n, e, a); end end
module tb_top;
    localparam int PC = 2;
    localparam logic [7:0] ID = 8'h5A; // Arbitrary fixed identifier.
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic field_on = 1'b1;
    logic fixed_id_opt = 1'b1;
    logic select_cmd = 1'b0;
    logic cmd_valid, cmd_write, cmd_ready, rd_valid, wr_done, erase_mode;
    logic [7:0] cmd_addr;
    logic [7:0] tag_selection_id;
    logic [31:0] cmd_wdata;
    logic [31:0] rd_data;
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;
    always #10 core_clk = ~core_clk;
    tag_memory_write_policy #(.PROG_CYCLES(PC), .FIXED_ID(ID)) DUT (.core_clk, .rst_n,
        .field_on, .fixed_id_opt, .select_cmd, .cmd_valid, .cmd_write, .cmd_addr, .cmd_wdata,
        .cmd_ready, .rd_valid, .rd_data, .wr_done, .erase_mode, .tag_selection_id);
    reader_model rdr (.core_clk, .cmd_ready, .rd_valid, .rd_data, .wr_done, .cmd_valid,
        .cmd_write, .cmd_addr, .cmd_wdata);
    ////////////////////////////////////////
    task automatic end_sim;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim
    // A hang is cut short well above the expected run length.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            end_sim();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic ok;
        rdr.xfer(0, 1'b1, a, d, q, ok);
        `CHK("write done", 1'b1, ok)
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        logic ok;
        rdr.xfer(2, 1'b0, a, 32'h0000_0000, q, ok);
        `CHK("read answer", 1'b1, ok)
        `CHK("block data", e, q)
    endtask : rd
    ////////////////////////////////////////
    // Main sequence; the fixed identifier option stays strapped on.
    initial begin
        logic [31:0] q;
        logic ok;
        repeat (6) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        `CHK("selection id", ID, tag_selection_id)
        rd(8'h05, 32'hFFFF_FFFE);
        rd(8'h06, 32'hFFFF_FFFF);
        wr(8'h05, 32'hFFFF_FFF0);
        wr(8'h05, 32'hFFFF_FFF0);
        wr(8'h05, 32'hFFFF_FFF8);
        rd(8'h05, 32'hFFFF_FFF0);
        wr(8'h05, 32'h0000_0000);
        rd(8'h05, 32'h0000_0000);
        wr(8'h06, 32'hFFDF_FFFF);
        `CHK("erase mode", 1'b1, erase_mode)
        wr(8'h01, 32'hA5A5_F0F0);
        rd(8'h01, 32'hA5A5_F0F0);
        @(posedge core_clk);
        #1;
        select_cmd = 1'b1;
        @(posedge core_clk);
        #1;
        select_cmd = 1'b0;
        `CHK("erase mode", 1'b0, erase_mode)
        wr(8'h01, 32'hFFFF_0FFF);
        rd(8'h01, 32'hA5A5_00F0);
        wr(8'h06, 32'hFFDF_FFFE);
        `CHK("erase mode", 1'b0, erase_mode)
        wr(8'h01, 32'h0000_0000);
        wr(8'h01, 32'hFFFF_FFFF);
        rd(8'h01, 32'h0000_0000);
        wr(8'h7F, 32'h1234_5678);
        wr(8'h7F, 32'h0000_FFFF);
        rd(8'h7F, 32'h0000_FFFF);
        for (int b = 7; b <= 10; b++) wr(8'(b), {4{8'(b)}});
        wr(8'hFF, 32'hFCFF_FFFF);
        rd(8'hFF, {24'hFC_FFFF, ID});
        for (int b = 7; b <= 10; b++) wr(8'(b), 32'h0000_0000);
        for (int b = 7; b <= 10; b++) rd(8'(b), b == 10 ? 32'h0000_0000 : {4{8'(b)}});
        wr(8'hFF, 32'hFFFF_FFFF);
        rd(8'hFF, {24'hFC_FFFF, ID});
        wr(8'h06, 32'hFFBF_FFFE);
        // The field drops just after a counter write is taken.
        fork
            rdr.xfer(0, 1'b1, 8'h06, 32'hFF9F_FFFE, q, ok);
            begin
                @(posedge core_clk iff (cmd_valid && cmd_ready));
                #1;
                field_on = 1'b0;
                repeat (8) @(posedge core_clk);
                #1;
                field_on = 1'b1;
            end
        join
        `CHK("aborted done", 1'b0, ok)
        `CHK("erase mode", 1'b0, erase_mode)
        rd(8'h06, 32'hFFBF_FFFE);
        wr(8'hFF, 32'h0000_0000);
        wr(8'hFF, 32'hFFFF_FFFF);
        rd(8'hFF, 32'h0000_0000);
        `CHK("selection id", 8'h00, tag_selection_id)
        end_sim();
    end
endmodule : tb_top
bind tag_memory_write_policy tag_mem_asserts #(.PROG_CYCLES(PROG_CYCLES)) chk (.core_clk,
    .rst_n, .field_on, .fixed_id_opt, .select_cmd, .cmd_valid, .cmd_write, .cmd_addr,
    .cmd_wdata, .cmd_ready, .rd_valid, .rd_data, .wr_done, .erase_mode, .tag_selection_id);
`default_nettype wire
